// File: hdl/jsa_top.sv
// slope converter controller with apb register file
//
// Decided for this implementation: the register addresses and the APB slave port.
`include "jsa_defines.svh"
`default_nettype none
module jsa_top #(
  parameter int NUM_CH  = 4,
  parameter int CNT_W   = 16,
  parameter int PADDR_W = 12
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               count_ref_clock,
  input  wire logic [3:0]         analog_channel_in,
  output logic                    comparator_bias_enable,
  output logic      [3:0]         discharge_on,
  output logic      [3:0]         comparator_test_out,
  output logic                    irq
);
  // register layout is fixed at four channels of up to 16 bits
  if (NUM_CH != 4 || CNT_W < 1 || CNT_W > 16 || PADDR_W < 7) begin : g_chk
    $error("jsa_top: unsupported parameter values");
  end

  logic [7:0]            intc_q;      // irq_combine_control_reg
  logic [7:0]            con_q;       // converter_control_reg
  logic [`JSA_DIV_W-1:0] div_q;       // reference divisor
  logic [`JSA_DIV_W-1:0] div_cnt_q;   // position within divisor
  logic                  ref_prev_q;  // last sampled reference
  logic                  tick_q;      // one count step
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic                  bias_q;
  logic                  irq_q;
  logic [3:0]            test_q;
  logic [3:0]            trip;        // synchronised comparators
  logic [3:0]            stop;        // per-channel stop flags
  logic [3:0]            req;         // enabled stop flags
  logic [3:0]            chan_clear;  // read reset or soft clear
  logic [3:0]            cnt_sel;     // a counter is addressed
  logic [`JSA_RD_W-1:0]  rd_mux;
  logic                  mapped;
  logic                  irq_d;
  jsa_pkg::jsa_bus_s     bus;
  jsa_pkg::jsa_chan_s    chan [NUM_CH];
  logic [5:0]            off;         // word offset of the access

  // word index from bits 5:2; higher bits must be zero
  assign off = {paddr[5:2], 2'b00};

  // qualified transfer phases; completion needs the strobe
  assign bus.setup   = psel && !penable;
  assign bus.wr_done = psel && penable && pready_q && pwrite;
  assign bus.rd_done = psel && penable && pready_q && !pwrite;

  // decode of the mapped words
  always_comb begin
    mapped  = 1'b0;
    cnt_sel = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      cnt_sel[i] = off == 6'(`JSA_OFF_CNT0 + i * `JSA_OFF_CNT_STEP);
    end
    if (paddr[PADDR_W-1:6] == '0) begin
      mapped = off == `JSA_OFF_INTC || off == `JSA_OFF_STAT ||
               off == `JSA_OFF_CON || off == `JSA_OFF_CLKDIV ||
               off == `JSA_OFF_CLR || |cnt_sel;
    end else begin
      cnt_sel = '0;
    end
  end

  // requests and stop flags as seen by status
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      stop[i] = chan[i].stopped;
    end
    req = stop & intc_q[3:0];
  end

  // read multiplexer; the clear word reads as zero
  always_comb begin
    rd_mux = '0;
    if (mapped) begin
      if (off == `JSA_OFF_INTC) begin
        rd_mux = {8'h00, intc_q};
      end else if (off == `JSA_OFF_STAT) begin
        rd_mux = {8'h00, req, stop};
      end else if (off == `JSA_OFF_CON) begin
        rd_mux = {8'h00, con_q};
      end else if (off == `JSA_OFF_CLKDIV) begin
        rd_mux = {10'h000, div_q};
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (cnt_sel[i]) begin
          rd_mux = chan[i].count;
        end
      end
    end
  end

  // apb answer: zero wait states, data caught in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q <= bus.setup;
      if (bus.setup) begin
        pslverr_q <= !mapped;
        // only a read of a selected word drives data
        prdata_q  <= pwrite ? 32'h0 : {16'h0000, rd_mux};
      end
    end
  end

  // software-writable control words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intc_q <= `JSA_RST_INTC;
      con_q  <= `JSA_RST_CON;
      div_q  <= `JSA_RST_CLKDIV;
    end else if (bus.wr_done && mapped) begin
      if (off == `JSA_OFF_INTC) begin
        intc_q <= pwdata[7:0];
      end
      if (off == `JSA_OFF_CON) begin
        con_q <= pwdata[7:0];
      end
      if (off == `JSA_OFF_CLKDIV) begin
        div_q <= pwdata[`JSA_DIV_W-1:0];
      end
    end
  end

  // reference edge divider: the only count rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
      div_cnt_q  <= '0;
      tick_q     <= 1'b0;
    end else begin
      ref_prev_q <= count_ref_clock;
      tick_q     <= 1'b0;
      // bus activity has no say in the count rate
      if (count_ref_clock && !ref_prev_q) begin
        if (div_cnt_q == div_q) begin
          div_cnt_q <= '0;
          tick_q    <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 1'b1;
        end
      end
    end
  end

  jsa_sync #(
    .W (4)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (analog_channel_in),
    .sync_out (trip)
  );

  // a counter read hands the channel back for a new cycle
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chan_clear[i] = (bus.rd_done && cnt_sel[i]) ||
                      (bus.wr_done && mapped && off == `JSA_OFF_CLR &&
                       pwdata[i]);
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    jsa_channel #(
      .CNT_W (CNT_W)
    ) u_ch (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (con_q[g]),
      .tick    (tick_q),
      .trip    (trip[g]),
      .clear   (chan_clear[g]),
      .result  (chan[g])
    );
  end

  // combine selects: any, all enabled, first pair, second pair
  always_comb begin
    irq_d = (intc_q[`JSA_INTC_ANY] && |req) ||
            (intc_q[`JSA_INTC_ALL] && |intc_q[3:0] &&
             &(req | ~intc_q[3:0])) ||
            (intc_q[`JSA_INTC_FIRST] && &req[1:0]) ||
            (intc_q[`JSA_INTC_SECOND] && &req[3:2]);
  end

  // pad and interrupt outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_q <= `JSA_RST_BIAS;  // bias powered as enables reset set
      irq_q  <= 1'b0;
      test_q <= '0;
    end else begin
      bias_q <= |intc_q[3:0];
      irq_q  <= irq_d;
      test_q <= trip;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign comparator_bias_enable = bias_q;
  assign discharge_on           = con_q[7:`JSA_CON_DCHG_LSB];
  assign comparator_test_out    = test_q;
  assign irq                    = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  write_intc_a: assert property (
    bus.wr_done && mapped && off == `JSA_OFF_INTC
    |=> intc_q == $past(pwdata[7:0]))
    else $error("interrupt control write lost");
  read_drive_a: assert property (
    pready && $past(pwrite) |-> prdata == 32'h0)
    else $error("data driven during write");
  index_sel_a: assert property (
    bus.setup && !pwrite && mapped && off == `JSA_OFF_CON
    |=> prdata[7:0] == $past(con_q))
    else $error("wrong register selected");
  ready_strobe_a: assert property (
    pready |-> $past(bus.setup))
    else $error("ready without a setup cycle");
  bias_on_a: assert property (
    bus.wr_done && mapped && off == `JSA_OFF_INTC && |pwdata[3:0]
    |=> ##1 comparator_bias_enable)
    else $error("bias not enabled");
  discharge_a: assert property (
    bus.wr_done && mapped && off == `JSA_OFF_CON
    |=> discharge_on == $past(pwdata[7:4]))
    else $error("discharge not following control");
  irq_any_a: assert property (
    intc_q[`JSA_INTC_ANY] && |req |=> irq)
    else $error("any-channel interrupt missing");
  irq_off_a: assert property (
    intc_q[7:4] == 4'h0 |=> !irq)
    else $error("interrupt with no combine select");
  read_reset_a: assert property (
    bus.rd_done && cnt_sel[0] && !trip[0] && con_q[0]
    |=> !chan[0].stopped)
    else $error("counter read did not reset channel");

  conv_stop_c: cover property (
    con_q[0] && !chan[0].stopped ##1 chan[0].stopped);
  irq_rise_c: cover property (!irq ##1 irq);
  cnt_read_c: cover property (bus.rd_done && |cnt_sel);
  slverr_c: cover property (pready && pslverr);
endmodule : jsa_top
`default_nettype wire

// File: hdl/jsa_defines.svh
// register offsets, field positions, reset values and widths
`ifndef JSA_DEFINES_SVH
`define JSA_DEFINES_SVH
`define JSA_OFF_INTC     6'h00
`define JSA_OFF_STAT     6'h04
`define JSA_OFF_CON      6'h08
`define JSA_OFF_CNT0     6'h0c
`define JSA_OFF_CNT_STEP 6'h04
`define JSA_OFF_CLKDIV   6'h1c
`define JSA_OFF_CLR      6'h24
`define JSA_RST_INTC     8'h0f
`define JSA_RST_CON      8'h00
`define JSA_RST_CLKDIV   6'h00
`define JSA_RST_BIAS     1'b1
`define JSA_INTC_ANY     4
`define JSA_INTC_ALL     5
`define JSA_INTC_FIRST   6
`define JSA_INTC_SECOND  7
`define JSA_CON_DCHG_LSB 4
`define JSA_STAT_REQ_LSB 4
`define JSA_DIV_W        6
`define JSA_RD_W         16
`endif

// File: hdl/jsa_pkg.sv
// shared types of the slope converter controller
`default_nettype none
package jsa_pkg;
  // one channel's result as seen by the register file
  typedef struct packed {
    logic        stopped;   // comparator has tripped
    logic [15:0] count;     // held count, zero extended
  } jsa_chan_s;
  // qualified bus events, one cycle each
  typedef struct packed {
    logic setup;            // first cycle of a transfer
    logic wr_done;          // write completes this edge
    logic rd_done;          // read completes this edge
  } jsa_bus_s;
endpackage : jsa_pkg
`default_nettype wire

// File: hdl/jsa_sync.sv
// two-flop synchroniser for comparator levels
`default_nettype none
module jsa_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;  // first stage, read only by the second
  logic [W-1:0] sync_q;  // second stage, safe to use

  // comparators change at any time relative to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : jsa_sync
`default_nettype wire

// File: hdl/jsa_channel.sv
// one slope converter channel: counter and stop flag
`default_nettype none
module jsa_channel #(
  parameter int CNT_W = 16
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               enable,   // 0 holds counter clear
  input  wire logic               tick,     // one pulse per count step
  input  wire logic               trip,     // synchronised comparator
  input  wire logic               clear,    // read or software clear
  output jsa_pkg::jsa_chan_s      result
);
  logic [CNT_W-1:0] count_q;  // ramp time so far
  logic             stop_q;   // latched comparator trip

  // counting, stop on trip, hold until read or software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      stop_q  <= 1'b0;
    end else if (!enable) begin
      count_q <= '0;
      stop_q  <= 1'b0;
    end else if (trip && !stop_q) begin
      stop_q <= 1'b1;  // a new trip beats a clear
    end else if (clear) begin
      count_q <= '0;
      stop_q  <= 1'b0;
    end else if (tick && !stop_q && count_q != '1) begin
      // saturate rather than wrap: a wrapped count looks short
      count_q <= count_q + 1'b1;
    end
  end

  assign result.stopped = stop_q;
  assign result.count   = 16'(count_q);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  clear_holds_a: assert property (
    !enable |=> count_q == '0 && !stop_q)
    else $error("disabled channel not cleared");
  // the flag may only drop again through a disable or a clear
  trip_stops_a: assert property (
    enable && trip && !stop_q |=> stop_q ##1
    (stop_q || $past(!enable) || $past(clear)))
    else $error("trip did not set stop flag");
  stop_holds_a: assert property (
    enable && stop_q && !clear |=> stop_q && $stable(count_q))
    else $error("stopped count moved");
  count_step_a: assert property (
    enable && tick && !stop_q && !trip && !clear && count_q != '1
    |=> count_q == $past(count_q) + 1'b1)
    else $error("count did not step on tick");
endmodule : jsa_channel
`default_nettype wire

// File: verif/jsa_rc_model.sv
// rc network and comparator model standing on the four joystick pads
`default_nettype none
module jsa_rc_model #(
  parameter int RAMP = 40  // pclk cycles to threshold, times channel number
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       comparator_bias_enable,
  input  wire logic [3:0] discharge_on,
  output logic      [3:0] analog_channel_in
);
  logic [15:0] ramp_q [4];  // charge time since the pad was released

  // capacitor charges only while its discharge transistor is off
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!presetn || discharge_on[i]) begin
        ramp_q[i] <= 16'h0000;
      end else if (ramp_q[i] != 16'hffff) begin
        ramp_q[i] <= ramp_q[i] + 16'h0001;  // saturate, never wrap
      end
    end
  end

  // an unbiased comparator cannot trip, so it reads low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      analog_channel_in[i] = comparator_bias_enable &&
        (ramp_q[i] >= 16'(RAMP * (i + 1)));
    end
  end
endmodule : jsa_rc_model
`default_nettype wire

// File: verif/tb_jsa_top.sv
// self-checking bench for the slope converter controller
`default_nettype none
module tb_jsa_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RAMP = 40;  // model ramp step in pclk cycles
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, count_ref_clock, bias, irq, er;
  logic [3:0]  ana, dchg, tout;
  int          error_cnt, check_count, n, ex;
  // combine settings and whether all four stopped channels raise irq
  logic [7:0]  ic [7] = '{8'h0f, 8'h1f, 8'h2f, 8'h43, 8'h8c, 8'h4c, 8'h27};
  logic        iq [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  jsa_top u_jsa_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_ref_clock(count_ref_clock),
    .analog_channel_in(ana), .comparator_bias_enable(bias),
    .discharge_on(dchg), .comparator_test_out(tout), .irq(irq)
  );
  jsa_rc_model #(.RAMP(RAMP)) u_jsa_rc_model (
    .pclk(pclk), .presetn(presetn), .comparator_bias_enable(bias),
    .discharge_on(dchg), .analog_channel_in(ana)
  );

  // 10 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // free running reference, a quarter of pclk, phase unrelated
  initial begin
    count_ref_clock = 1'b0;
    #137;
    forever #200 count_ref_clock = ~count_ref_clock;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] got);
    check_count++;
    if (got !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, got);
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, pready);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);  // lets the release land before the next setup
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // every readable word but the clear word, and the bias, discharge and irq outputs, after a cold reset
  task automatic chk_reset();
    for (int i = 0; i < 8; i++) begin
      rdchk(12'(4 * i), (i == 0) ? 32'h0f : 32'h0, "reset word");
    end
    chk("bias", 32'h1, bias);
    chk("discharge", 32'h0, dchg);
    chk("irq", 32'h0, irq);
  endtask : chk_reset

  initial begin
    error_cnt = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    do_reset();
    chk_reset();
    $display("test reset values done");
    // plain register traffic, refused places, then a mid-run reset
    // only the slow channels 2 and 4 run, so no stop flag rises here
    apb(1'b1, 12'h008, 32'h0000005a);
    rdchk(12'h008, 32'h0000005a, "control");
    chk("discharge", 32'h5, dchg);
    apb(1'b1, 12'h01c, 32'h0000003f);
    rdchk(12'h01c, 32'h0000003f, "divisor");
    apb(1'b1, 12'h004, 32'h000000ff);
    rdchk(12'h004, 32'h0, "status write ignored");
    rdchk(12'h028, 32'h0, "unmapped");
    chk("unmapped err", 32'h1, er);
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge pclk);
    chk("bias off", 32'h0, bias);
    do_reset();
    chk_reset();
    $display("test registers done");
    // discharge, then release and count together
    apb(1'b1, 12'h008, 32'h000000f0);
    chk("discharge", 32'hf, dchg);
    repeat (5) @(posedge pclk);
    apb(1'b1, 12'h008, 32'h0000000f);
    n = 0;
    rd = 32'h0;
    while (rd[3:0] !== 4'hf && n < 200) begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end
    chk("all stopped", 32'hff, rd);
    if (n >= 200) begin
      end_sim();
    end
    chk("test out", 32'hf, tout);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, 12'h000, {24'h0, ic[k]});
      repeat (2) @(posedge pclk);
      chk("irq", {31'h0, iq[k]}, irq);
      rdchk(12'h004, {24'h0, ic[k][3:0], 4'hf}, "status");
    end
    apb(1'b1, 12'h000, 32'h0000001f);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(12 + 4 * i), 32'h0);
      ex = RAMP * (i + 1) / 4 + 1;
      check_count++;
      if (rd > 32'(ex + 2) || rd + 32'h2 < 32'(ex)) begin
        error_cnt++;
        $display("mismatch count %0d expected %0d seen %0d", i, ex, rd);
      end
      rdchk(12'(12 + 4 * i), 32'h0, "count after read");
    end
    // stop flags hold with the comparator low, until read or cleared
    apb(1'b1, 12'h008, 32'h000000ff);
    repeat (4) @(posedge pclk);
    rdchk(12'h004, 32'hff, "stop held");
    rdchk(12'h00c, 32'h0, "count 0 read");
    apb(1'b1, 12'h024, 32'h00000002);
    rdchk(12'h004, 32'hcc, "status after clears");
    rdchk(12'h024, 32'h0, "clear word");
    apb(1'b1, 12'h008, 32'h000000f0);
    repeat (2) @(posedge pclk);
    rdchk(12'h004, 32'h0, "status cleared");
    chk("irq cleared", 32'h0, irq);
    $display("test conversion done");
    // a divisor of one halves the count rate
    apb(1'b1, 12'h01c, 32'h00000001);
    apb(1'b1, 12'h008, 32'h00000001);
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 200) begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end
    chk("ch1 stopped", 32'h11, rd);
    apb(1'b0, 12'h00c, 32'h0);
    ex = RAMP / 8 + 1;
    check_count++;
    if (rd > 32'(ex + 2) || rd + 32'h2 < 32'(ex)) begin
      error_cnt++;
      $display("mismatch slow count expected %0d seen %0d", ex, rd);
    end
    $display("test divisor done");
    end_sim();
  end
endmodule : tb_jsa_top
`default_nettype wire
